// [include/sgc_pkg.sv]
// Constants and carrier types for the global control register pair
package sgc_pkg;
  localparam logic [7:0] GC0_OFS = 8'h02;
  localparam logic [7:0] GC1_OFS = 8'h03;
  localparam int GC0_SRST   = 6;
  localparam int GC0_DFL    = 5;
  localparam int GC0_SFL    = 4;
  localparam int GC0_STRICT = 1;
  localparam int GC0_LAGE   = 0;
  localparam logic [7:0] GC0_RSV_ONES = 8'h0C;
  localparam int GC1_BIG  = 6;
  localparam int GC1_TXD  = 5;
  localparam int GC1_RXD  = 4;
  localparam int GC1_LCHK = 3;
  localparam int GC1_AGE  = 2;
  localparam int GC1_FAST = 1;
  localparam int GC1_ABO  = 0;
  localparam logic [7:0] GC0_RST = 8'h00;
  localparam logic [7:0] GC1_RST = 8'h04;
  localparam int NPORT = 5;
  localparam int MSK_DYN   = 0;
  localparam int MSK_STAT  = 1;
  localparam int MSK_PURGE = 2;
  localparam logic [15:0] PAUSE_TYPE = 16'h8808;
  localparam logic [47:0] PAUSE_DA   = 48'h0180C2000001;
  localparam logic [15:0] LEN_FIELD_LIM = 16'h05DC;
  localparam logic [11:0] BIG_MAX = 12'h800;
  localparam logic [11:0] STD_MAX = 12'h5F2;
  localparam longint CLK_HZ      = 10000000;
  localparam longint AGE_NORM_S  = 300;
  localparam longint AGE_FAST_US = 800;
  localparam longint AGE_NORM_CYC = AGE_NORM_S * CLK_HZ;
  localparam longint AGE_FAST_CYC = AGE_FAST_US * CLK_HZ / 1000000;

  typedef enum logic {SGC_WK_IDLE, SGC_WK_SCAN} sgc_wstate_e;

  typedef struct packed {
    logic             valid;
    logic             stat;
    logic             mcast;
    logic [NPORT-1:0] fwd;
    logic [2:0]       src;
  } sgc_ent_s;

  typedef struct packed {
    logic        vld;
    logic [15:0] tl;
    logic [47:0] da;
    logic [11:0] len;
    logic [11:0] plen;
    logic        is_fc;
  } sgc_frm_s;

  typedef struct packed {
    logic [7:0]       gc0;
    logic [7:0]       gc1;
    logic             strap_done;
    logic [2:0]       pend;
    logic [NPORT-1:0] link_prev;
    logic             purge_pend;
    logic             fast_once;
    logic [31:0]      age_cnt;
    logic             age_tick;
    logic [7:0]       rdata;
    logic             rvalid;
    logic             frm_vld;
    logic             frm_drop;
    logic             tx_fc;
    logic             rx_fc;
  } sgc_top_s;
endpackage

// [logic/sgc_flush_walk.sv]
// Address table walker that removes entries matching the flush modes
`timescale 1ns/10ps
module sgc_flush_walk #(
  parameter int DEPTH = 1024
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     srst,
  input  wire logic                     start,
  input  wire logic [2:0]               start_mask,
  input  wire sgc_pkg::sgc_ent_s        ent,
  input  wire logic [sgc_pkg::NPORT-1:0] learn_dis,
  output logic                          busy,
  output logic [2:0]                    run_mask,
  output logic [$clog2(DEPTH)-1:0]      idx,
  output logic                          rm_stb,
  output logic [$clog2(DEPTH)-1:0]      rm_idx
);
  localparam int IW = $clog2(DEPTH);
  typedef struct packed {
    sgc_pkg::sgc_wstate_e st;
    logic [2:0]           msk;
    logic [IW-1:0]        idx;
    logic                 rm;
    logic [IW-1:0]        rm_idx;
  } sgc_walk_s;
  localparam sgc_walk_s WALK_RST = '{sgc_pkg::SGC_WK_IDLE, 3'h0, '0, 1'b0, '0};

  sgc_walk_s q;
  sgc_walk_s d;
  logic      dyn_hit;
  logic      stat_hit;
  logic      hit;

  always_comb
  begin
    d = q;
    d.rm = 1'b0;
    dyn_hit = !ent.stat && (ent.src < 3'(sgc_pkg::NPORT)) && learn_dis[ent.src];
    stat_hit = ent.stat && $onehot(ent.fwd) && !ent.mcast && |(ent.fwd & learn_dis);
    hit = ent.valid && ((q.msk[sgc_pkg::MSK_DYN] && dyn_hit)
          || (q.msk[sgc_pkg::MSK_STAT] && stat_hit)
          || (q.msk[sgc_pkg::MSK_PURGE] && !ent.stat));
    unique case (q.st)
      sgc_pkg::SGC_WK_IDLE:
      begin
        if (start && |start_mask)
        begin
          d.st = sgc_pkg::SGC_WK_SCAN;
          d.msk = start_mask;
          d.idx = '0;
        end
      end
      sgc_pkg::SGC_WK_SCAN:
      begin
        if (hit)
        begin
          d.rm = 1'b1;
          d.rm_idx = q.idx;
        end
        if (q.idx == IW'(DEPTH - 1))
        begin
          d.st = sgc_pkg::SGC_WK_IDLE;
          d.msk = 3'h0;
        end
        else
          d.idx = q.idx + 1'b1;
      end
    endcase
    if (srst)
      d = WALK_RST;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      q <= WALK_RST;
    else
      q <= d;
  end

  assign busy = (q.st == sgc_pkg::SGC_WK_SCAN);
  assign run_mask = q.msk;
  assign idx = q.idx;
  assign rm_stb = q.rm;
  assign rm_idx = q.rm_idx;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_STAT_SINGLE: assert property (
    (busy && !srst && q.msk == 3'h2 && ent.valid && !$onehot(ent.fwd)) |=> !rm_stb)
    else $error("static flush removed a multi-port entry");
  AST_WALK_END: assert property (
    (busy && !srst && q.idx == IW'(DEPTH - 1)) |=> !busy && run_mask == 3'h0)
    else $error("walker did not finish after last entry");
endmodule

// [logic/sgc_global_ctrl.sv]
// Global control register pair with flush, aging and frame filter control
`timescale 1ns/10ps
module sgc_global_ctrl #(
  parameter int          DEPTH    = 1024,
  parameter logic [31:0] NORM_CYC = 32'(sgc_pkg::AGE_NORM_CYC),
  parameter logic [31:0] FAST_CYC = 32'(sgc_pkg::AGE_FAST_CYC)
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        strap_pause_dis,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [7:0]                       reg_rdata,
  output logic                             reg_rvalid,
  input  wire logic [sgc_pkg::NPORT-1:0]   link_up,
  input  wire logic [sgc_pkg::NPORT-1:0]   learn_dis,
  input  wire logic                        an_tx_pause,
  input  wire logic                        an_rx_pause,
  input  wire sgc_pkg::sgc_frm_s           frm,
  input  wire sgc_pkg::sgc_ent_s           ent,
  output logic [$clog2(DEPTH)-1:0]         tbl_idx,
  output logic                             tbl_rm,
  output logic [$clog2(DEPTH)-1:0]         tbl_rm_idx,
  output logic                             soft_rst,
  output logic                             age_tick,
  output logic                             frm_drop_vld,
  output logic                             frm_drop,
  output logic                             tx_fc_en,
  output logic                             rx_fc_en,
  output logic                             big_frame_en,
  output logic                             len_check_en,
  output logic                             aggr_backoff_en
);
  localparam sgc_pkg::sgc_top_s TOP_RST = '{
    gc0: sgc_pkg::GC0_RST,
    gc1: sgc_pkg::GC1_RST,
    default: '0
  };

  sgc_pkg::sgc_top_s q;
  sgc_pkg::sgc_top_s d;
  logic                     wr0;
  logic                     wr1;
  logic                     walk_busy;
  logic [2:0]               run_mask;
  logic                     start;
  logic [sgc_pkg::NPORT-1:0] link_fall;
  logic [31:0]              period;
  logic                     age_wrap;
  logic                     fc_drop;
  logic                     len_bad;
  logic [11:0]              max_len;
  logic                     srst;

  assign srst = q.gc0[sgc_pkg::GC0_SRST];
  // Walker only starts from idle, so requests made mid-pass wait for the next one
  assign start = !walk_busy && |q.pend && !srst;

  sgc_flush_walk #(
    .DEPTH (DEPTH)
  ) u_walk (
    .core_clk   (core_clk),
    .rst        (rst),
    .srst       (srst),
    .start      (start),
    .start_mask (q.pend),
    .ent        (ent),
    .learn_dis  (learn_dis),
    .busy       (walk_busy),
    .run_mask   (run_mask),
    .idx        (tbl_idx),
    .rm_stb     (tbl_rm),
    .rm_idx     (tbl_rm_idx)
  );

  always_comb
  begin
    d = q;
    wr0 = reg_wr && (reg_addr == sgc_pkg::GC0_OFS);
    wr1 = reg_wr && (reg_addr == sgc_pkg::GC1_OFS);
    link_fall = q.link_prev & ~link_up;
    period = (q.gc1[sgc_pkg::GC1_FAST] || q.fast_once) ? FAST_CYC : NORM_CYC;
    age_wrap = (q.age_cnt >= period - 32'h1);
    d.link_prev = link_up;
    d.age_tick = 1'b0;
    d.frm_vld = 1'b0;
    d.frm_drop = 1'b0;

    // Strap is caught on the first edge after reset release
    if (!q.strap_done)
    begin
      d.strap_done = 1'b1;
      d.gc1[sgc_pkg::GC1_TXD] = strap_pause_dis;
      d.gc1[sgc_pkg::GC1_RXD] = strap_pause_dis;
    end

    // Pending flushes are handed to the walker; a write in the same cycle still lands
    if (start)
      d.pend = 3'h0;
    if (wr0)
    begin
      d.gc0[sgc_pkg::GC0_SRST] = reg_wdata[sgc_pkg::GC0_SRST];
      d.gc0[sgc_pkg::GC0_STRICT] = reg_wdata[sgc_pkg::GC0_STRICT];
      d.gc0[sgc_pkg::GC0_LAGE] = reg_wdata[sgc_pkg::GC0_LAGE];
      if (reg_wdata[sgc_pkg::GC0_DFL])
        d.pend[sgc_pkg::MSK_DYN] = 1'b1;
      if (reg_wdata[sgc_pkg::GC0_SFL])
        d.pend[sgc_pkg::MSK_STAT] = 1'b1;
    end
    if (wr1)
    begin
      d.gc1 = reg_wdata & 8'h7F;
    end

    // Read data always reflects the state before this cycle's write
    d.rvalid = reg_rd;
    if (reg_rd)
    begin
      d.rdata = 8'h00;
      if (reg_addr == sgc_pkg::GC0_OFS)
      begin
        d.rdata = (q.gc0 & 8'h43) | sgc_pkg::GC0_RSV_ONES;
        d.rdata[sgc_pkg::GC0_DFL] = q.pend[sgc_pkg::MSK_DYN]
          || run_mask[sgc_pkg::MSK_DYN];
        d.rdata[sgc_pkg::GC0_SFL] = q.pend[sgc_pkg::MSK_STAT]
          || run_mask[sgc_pkg::MSK_STAT];
      end
      else if (reg_addr == sgc_pkg::GC1_OFS)
        d.rdata = q.gc1;
    end

    // Timer runs when aging is on or a purge waits for its tick
    if (q.gc1[sgc_pkg::GC1_AGE] || q.purge_pend)
    begin
      if (age_wrap)
      begin
        d.age_cnt = 32'h0;
        d.age_tick = q.gc1[sgc_pkg::GC1_AGE];
        d.fast_once = 1'b0;
        if (q.purge_pend)
        begin
          d.purge_pend = 1'b0;
          d.pend[sgc_pkg::MSK_PURGE] = 1'b1;
        end
      end
      else if (!(|link_fall && q.gc0[sgc_pkg::GC0_LAGE]))
        d.age_cnt = q.age_cnt + 32'h1;
    end

    // Link loss schedules a purge; link age pulls the next tick in
    // Placed after the timer so a fall in a wrap cycle is never lost
    if (|link_fall)
    begin
      d.purge_pend = 1'b1;
      if (q.gc0[sgc_pkg::GC0_LAGE])
      begin
        d.fast_once = 1'b1;
        d.age_cnt = 32'h0;
      end
    end

    // Frame filter decision, one cycle after the header is offered
    fc_drop = q.gc0[sgc_pkg::GC0_STRICT]
      ? (frm.tl == sgc_pkg::PAUSE_TYPE || frm.da == sgc_pkg::PAUSE_DA)
      : frm.is_fc;
    len_bad = q.gc1[sgc_pkg::GC1_LCHK] && (frm.tl < sgc_pkg::LEN_FIELD_LIM)
      && (frm.tl[11:0] != frm.plen || |frm.tl[15:12]);
    max_len = q.gc1[sgc_pkg::GC1_BIG] ? sgc_pkg::BIG_MAX : sgc_pkg::STD_MAX;
    if (frm.vld)
    begin
      d.frm_vld = 1'b1;
      d.frm_drop = fc_drop || len_bad || (frm.len > max_len);
    end

    d.tx_fc = an_tx_pause && !q.gc1[sgc_pkg::GC1_TXD];
    d.rx_fc = an_rx_pause && !q.gc1[sgc_pkg::GC1_RXD];

    // Soft reset clears flush, aging, frame and flow-control state; read data still updates and configuration bits stay untouched
    if (srst)
    begin
      d.pend = 3'h0;
      d.purge_pend = 1'b0;
      d.fast_once = 1'b0;
      d.age_cnt = 32'h0;
      d.age_tick = 1'b0;
      d.frm_vld = 1'b0;
      d.frm_drop = 1'b0;
      d.tx_fc = 1'b0;
      d.rx_fc = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      q <= TOP_RST;
    else
      q <= d;
  end

  assign reg_rdata = q.rdata;
  assign reg_rvalid = q.rvalid;
  assign soft_rst = q.gc0[sgc_pkg::GC0_SRST];
  assign age_tick = q.age_tick;
  assign frm_drop_vld = q.frm_vld;
  assign frm_drop = q.frm_drop;
  assign tx_fc_en = q.tx_fc;
  assign rx_fc_en = q.rx_fc;
  assign big_frame_en = q.gc1[sgc_pkg::GC1_BIG];
  assign len_check_en = q.gc1[sgc_pkg::GC1_LCHK];
  assign aggr_backoff_en = q.gc1[sgc_pkg::GC1_ABO];

  // Helper: cycles a link-age purge has waited for its tick
  logic [31:0] ast_wait_q;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ast_wait_q <= 32'h0;
    else if (q.fast_once && q.purge_pend)
      ast_wait_q <= ast_wait_q + 32'h1;
    else
      ast_wait_q <= 32'h0;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_SRST_HALT: assert property (
    srst |=> !frm_drop_vld && !age_tick && !tbl_rm)
    else $error("frame or table activity during soft reset");
  AST_SRST_KEEP: assert property (
    (srst && !wr1 && q.strap_done) |=> $stable(q.gc1))
    else $error("configuration changed by soft reset");
  AST_DFL_READ: assert property (
    (wr0 && reg_wdata[sgc_pkg::GC0_DFL] && !srst && !reg_wdata[sgc_pkg::GC0_SRST])
    ##1 (reg_rd && reg_addr == sgc_pkg::GC0_OFS) |=> reg_rdata[sgc_pkg::GC0_DFL])
    else $error("dynamic flush bit not reading busy");
  AST_SFL_START: assert property (
    (wr0 && reg_wdata[sgc_pkg::GC0_SFL] && !reg_wdata[sgc_pkg::GC0_SRST] && !srst)
    |=> q.pend[sgc_pkg::MSK_STAT] || run_mask[sgc_pkg::MSK_STAT])
    else $error("static flush request lost");
  AST_STRICT_DROP: assert property (
    (frm.vld && !srst && q.gc0[sgc_pkg::GC0_STRICT] && frm.tl == sgc_pkg::PAUSE_TYPE)
    |=> frm_drop_vld && frm_drop)
    else $error("strict mode kept a pause type frame");
  AST_PLAIN_PASS: assert property (
    (frm.vld && !srst && !q.gc0[sgc_pkg::GC0_STRICT] && !frm.is_fc
     && !q.gc1[sgc_pkg::GC1_LCHK] && frm.len <= sgc_pkg::STD_MAX) |=> !frm_drop)
    else $error("non-strict mode dropped a normal frame");
  AST_FAST_BOUND: assert property (
    ast_wait_q < FAST_CYC + 32'h2)
    else $error("link age purge waited past the fast period");
  AST_LEN_DROP: assert property (
    (frm.vld && !srst && q.gc1[sgc_pkg::GC1_LCHK] && frm.tl < sgc_pkg::LEN_FIELD_LIM
     && frm.tl[11:0] != frm.plen) |=> frm_drop)
    else $error("length mismatch not dropped");
  AST_BIG_DROP: assert property (
    (frm.vld && !srst && !q.gc1[sgc_pkg::GC1_BIG] && frm.len > sgc_pkg::STD_MAX)
    |=> frm_drop)
    else $error("oversize frame kept");
  AST_TX_OFF: assert property (
    (q.gc1[sgc_pkg::GC1_TXD] && !wr1) |=> ##1 !tx_fc_en)
    else $error("transmit flow control on while disabled");
  AST_RX_OFF: assert property (
    (q.gc1[sgc_pkg::GC1_RXD] && !wr1) |=> ##1 !rx_fc_en)
    else $error("receive flow control on while disabled");
  AST_NO_AGE: assert property (
    !q.gc1[sgc_pkg::GC1_AGE] |=> !age_tick)
    else $error("aging tick while aging disabled");

  // Strap, write and control paths of the second register
  AST_STRAP_LOAD: assert property (
    (!q.strap_done && !wr1) |=> q.gc1[sgc_pkg::GC1_TXD] == $past(strap_pause_dis)
      && q.gc1[sgc_pkg::GC1_RXD] == $past(strap_pause_dis))
    else $error("pause disable bits not loaded from strap");
  AST_ABO_WRITE: assert property (
    wr1 |=> aggr_backoff_en == $past(reg_wdata[sgc_pkg::GC1_ABO]))
    else $error("back-off enable does not follow write");
  AST_TX_FOLLOW: assert property (
    (!q.gc1[sgc_pkg::GC1_TXD] && an_tx_pause && !srst) |=> tx_fc_en)
    else $error("transmit flow control ignored negotiation");
  AST_RX_FOLLOW: assert property (
    (!q.gc1[sgc_pkg::GC1_RXD] && an_rx_pause && !srst) |=> rx_fc_en)
    else $error("receive flow control ignored negotiation");
  AST_BIG_KEEP: assert property (
    (frm.vld && !srst && q.gc1[sgc_pkg::GC1_BIG] && !q.gc1[sgc_pkg::GC1_LCHK]
     && !q.gc0[sgc_pkg::GC0_STRICT] && !frm.is_fc && frm.len <= sgc_pkg::BIG_MAX)
    |=> !frm_drop)
    else $error("large frame dropped with large frames enabled");

  // Flush request and completion
  AST_DFL_ZERO: assert property (
    (wr0 && !reg_wdata[sgc_pkg::GC0_DFL] && !q.pend[sgc_pkg::MSK_DYN])
    |=> !q.pend[sgc_pkg::MSK_DYN])
    else $error("writing zero started a dynamic flush");
  AST_FLUSH_IDLE: assert property (
    (reg_rd && reg_addr == sgc_pkg::GC0_OFS && !walk_busy && q.pend == 3'h0)
    |=> !reg_rdata[sgc_pkg::GC0_DFL] && !reg_rdata[sgc_pkg::GC0_SFL])
    else $error("flush bit reads busy with no flush running");

  // Aging timer and link loss purge
  AST_AGE_WRAP: assert property (
    (q.gc1[sgc_pkg::GC1_AGE] && !q.gc1[sgc_pkg::GC1_FAST] && !q.fast_once && !srst
     && q.age_cnt >= NORM_CYC - 32'h1) |=> age_tick)
    else $error("no aging tick at end of normal period");
  AST_FAST_WRAP: assert property (
    (q.gc1[sgc_pkg::GC1_FAST] && q.gc1[sgc_pkg::GC1_AGE] && !srst
     && q.age_cnt >= FAST_CYC - 32'h1) |=> q.age_cnt == 32'h0)
    else $error("fast aging period overran");
  AST_LINK_FAST: assert property (
    (|link_fall && q.gc0[sgc_pkg::GC0_LAGE] && !srst)
    |=> q.fast_once && q.purge_pend && q.age_cnt == 32'h0)
    else $error("link loss did not restart a fast age cycle");
  AST_PURGE_QUEUE: assert property (
    (q.purge_pend && age_wrap && !srst)
    |=> q.pend[sgc_pkg::MSK_PURGE] || run_mask[sgc_pkg::MSK_PURGE])
    else $error("link loss purge not queued at aging tick");

  COV_DYN_FLUSH: cover property (start && q.pend[sgc_pkg::MSK_DYN]);
  COV_STAT_RM: cover property (run_mask[sgc_pkg::MSK_STAT] && tbl_rm);
  COV_PURGE: cover property (start && q.pend[sgc_pkg::MSK_PURGE]);
  COV_STRICT: cover property (frm_drop_vld && frm_drop && q.gc0[sgc_pkg::GC0_STRICT]);
  COV_LINK_FAST: cover property (q.fast_once && q.purge_pend && age_wrap);
endmodule

// [sim/test_switch_global_control_regs.sv]
// Self-checking bench for the global control register pair
`timescale 1ns/10ps
module test_switch_global_control_regs;
  localparam int DEP = 16;
  logic              core_clk;
  logic              rst;
  logic              strap;
  logic [7:0]        reg_addr;
  logic [7:0]        reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [7:0]        rdata;
  logic              rvalid;
  logic [4:0]        link_up;
  logic [4:0]        learn_dis;
  logic              an_tx;
  logic              an_rx;
  sgc_pkg::sgc_frm_s frm;
  sgc_pkg::sgc_ent_s tbl [DEP];
  sgc_pkg::sgc_ent_s ent_w;
  logic [3:0]        tbl_idx;
  logic              rm;
  logic [3:0]        rm_idx;
  logic              soft_rst;
  logic              age_tick;
  logic              dvld;
  logic              drop;
  logic              tx_fc;
  logic              rx_fc;
  logic              big;
  logic              lchk;
  logic              abo;
  logic [15:0]       removed;
  logic [7:0]        v;
  int                gap_cnt;
  int                last_gap;
  int                ticks;
  int                cyc;
  int                num_errors;
  int                comparisons;

  // Short counts keep the aging scenarios inside the run budget
  sgc_global_ctrl #(.DEPTH(DEP), .NORM_CYC(32'h0000_00C8), .FAST_CYC(32'h0000_0014)) dut_u (
    .core_clk(core_clk), .rst(rst), .strap_pause_dis(strap), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .link_up(link_up), .learn_dis(learn_dis), .an_tx_pause(an_tx),
    .an_rx_pause(an_rx), .frm(frm), .ent(ent_w), .tbl_idx(tbl_idx), .tbl_rm(rm),
    .tbl_rm_idx(rm_idx), .soft_rst(soft_rst), .age_tick(age_tick), .frm_drop_vld(dvld),
    .frm_drop(drop), .tx_fc_en(tx_fc), .rx_fc_en(rx_fc), .big_frame_en(big),
    .len_check_en(lchk), .aggr_backoff_en(abo));

  // Table read is combinational, as the walker expects
  assign ent_w = tbl[tbl_idx];

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (rm === 1'b1)
      removed[rm_idx] <= 1'b1;
    gap_cnt <= (age_tick === 1'b1) ? 0 : gap_cnt + 1;
    if (age_tick === 1'b1)
    begin
      last_gap <= gap_cnt + 1;
      ticks <= ticks + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
    step();
  endtask

  task automatic rdv(input logic [7:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    step();
    reg_rd = 1'b0;
    chk("read valid", rvalid, 1'b1);
    v = rdata;
    step();
  endtask

  task automatic do_reset(input logic s);
    strap = s;
    rst = 1'b1;
    step();
    step();
    rst = 1'b0;
    step();
  endtask

  task automatic wait_tick(input int lim);
    step();
    for (int n = 0; n < lim && age_tick !== 1'b1; n++)
      step();
    chk("aging tick", age_tick, 1'b1);
  endtask

  task automatic send(input logic [15:0] tl, input logic [47:0] da, input logic [11:0] len,
                      input logic [11:0] plen, input logic fc, input logic ev, input logic ed);
    frm = '{vld: 1'b1, tl: tl, da: da, len: len, plen: plen, is_fc: fc};
    step();
    frm.vld = 1'b0;
    chk("drop valid", dvld, ev);
    if (ev)
      chk("drop", drop, ed);
    step();
  endtask

  function automatic logic [15:0] exp_mask(input int m, input logic [4:0] ld);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < DEP; i++)
      if (m == 1)
        r[i] = tbl[i].valid && tbl[i].stat && !tbl[i].mcast && $onehot(tbl[i].fwd)
               && |(tbl[i].fwd & ld);
      else
        r[i] = tbl[i].valid && !tbl[i].stat && (m == 2 || ld[tbl[i].src]);
    return r;
  endfunction

  task automatic t_reset();
    do_reset(1'b1);
    rdv(8'h03);
    chk("gc1 strap", v, 8'h34);
    wr(8'h03, 8'h14);
    rdv(8'h03);
    chk("gc1 tx only", v, 8'h14);
    do_reset(1'b0);
    rdv(8'h02);
    chk("gc0 reset", v, 8'h0C);
    rdv(8'h03);
    chk("gc1 reset", v, 8'h04);
  endtask

  task automatic t_regs();
    wr(8'h03, 8'hFF);
    rdv(8'h03);
    chk("gc1 all", v, 8'h7F);
    chk("big", big, 1'b1);
    chk("len check", lchk, 1'b1);
    chk("backoff", abo, 1'b1);
    wr(8'h03, 8'h04);
    rdv(8'h03);
    chk("big off", big | lchk | abo, 1'b0);
    wr(8'h04, 8'hFF);
    rdv(8'h04);
    chk("unmapped", v, 8'h00);
    wr(8'h02, 8'h83);
    rdv(8'h02);
    chk("gc0 bits", v, 8'h0F);
  endtask

  task automatic t_frames();
    send(16'h8808, 48'h0, 12'h040, 12'h000, 1'b0, 1'b1, 1'b1);
    send(16'h0800, 48'h0180C2000001, 12'h040, 12'h000, 1'b0, 1'b1, 1'b1);
    send(16'h0800, 48'h0, 12'h040, 12'h000, 1'b1, 1'b1, 1'b0);
    wr(8'h02, 8'h00);
    send(16'h8808, 48'h0, 12'h040, 12'h000, 1'b0, 1'b1, 1'b0);
    send(16'h0800, 48'h0, 12'h040, 12'h000, 1'b1, 1'b1, 1'b1);
    wr(8'h03, 8'h0C);
    send(16'h0064, 48'h0, 12'h040, 12'h032, 1'b0, 1'b1, 1'b1);
    send(16'h0064, 48'h0, 12'h040, 12'h064, 1'b0, 1'b1, 1'b0);
    send(16'h05DC, 48'h0, 12'h040, 12'h032, 1'b0, 1'b1, 1'b0);
    wr(8'h03, 8'h04);
    send(16'h0800, 48'h0, 12'h5F2, 12'h000, 1'b0, 1'b1, 1'b0);
    send(16'h0800, 48'h0, 12'h5F3, 12'h000, 1'b0, 1'b1, 1'b1);
    wr(8'h03, 8'h44);
    send(16'h0800, 48'h0, 12'h800, 12'h000, 1'b0, 1'b1, 1'b0);
    send(16'h0800, 48'h0, 12'h801, 12'h000, 1'b0, 1'b1, 1'b1);
  endtask

  task automatic t_fc();
    for (int i = 0; i < 8; i++)
    begin
      an_tx = i[2];
      an_rx = i[2];
      wr(8'h03, {2'b00, i[1:0], 4'h4});
      step();
      step();
      chk("tx flow", tx_fc, i[2] & !i[1]);
      chk("rx flow", rx_fc, i[2] & !i[0]);
    end
  endtask

  task automatic t_flush();
    learn_dis = 5'h06;
    for (int m = 0; m < 2; m++)
    begin
      removed = '0;
      wr(8'h02, m ? 8'h10 : 8'h20);
      rdv(8'h02);
      chk("flush busy", v[5-m], 1'b1);
      for (int n = 0; n < 100 && v[5-m] === 1'b1; n++)
        rdv(8'h02);
      step();
      chk("flush cleared", v, 8'h0C);
      chk("removed", removed, exp_mask(m, 5'h06));
    end
  endtask

  task automatic t_soft();
    wr(8'h03, 8'h4D);
    wr(8'h02, 8'h40);
    step();
    chk("soft reset", soft_rst, 1'b1);
    send(16'h8808, 48'h0, 12'h040, 12'h000, 1'b1, 1'b0, 1'b0);
    chk("tx flow held", tx_fc, 1'b0);
    rdv(8'h03);
    chk("gc1 kept", v, 8'h4D);
    wr(8'h02, 8'h00);
    step();
    chk("soft reset off", soft_rst, 1'b0);
    wr(8'h03, 8'h04);
  endtask

  task automatic t_aging();
    int t0;
    wait_tick(250);
    wait_tick(250);
    step();
    chk("normal period", 16'(last_gap), 16'h00C8);
    wr(8'h03, 8'h06);
    wait_tick(250);
    wait_tick(30);
    step();
    chk("fast period", 16'(last_gap), 16'h0014);
    wr(8'h03, 8'h00);
    step();
    step();
    t0 = ticks;
    repeat (300) step();
    chk("aging off", 16'(ticks - t0), 16'h0000);
  endtask

  task automatic t_link();
    wr(8'h03, 8'h04);
    wr(8'h02, 8'h01);
    removed = '0;
    link_up = 5'h1D;
    wait_tick(25);
    repeat (40) step();
    chk("purged", removed, exp_mask(2, 5'h00));
    wait_tick(210);
    step();
    chk("normal again", 16'(last_gap), 16'h00C8);
    link_up = 5'h1F;
  endtask

  initial
  begin
    rst = 1'b1;
    strap = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    link_up = 5'h1F;
    learn_dis = 5'h00;
    an_tx = 1'b0;
    an_rx = 1'b0;
    frm = '0;
    removed = '0;
    {gap_cnt, last_gap, ticks, cyc, num_errors, comparisons} = '0;
    for (int i = 0; i < DEP; i++)
    begin
      tbl[i].valid = (i != 7);
      tbl[i].stat = i[0];
      tbl[i].mcast = (i == 11);
      tbl[i].fwd = (i == 9) ? 5'h06 : 5'h01 << (i % 5);
      tbl[i].src = 3'(i % 5);
    end
    t_reset();
    t_regs();
    t_frames();
    t_fc();
    t_flush();
    t_soft();
    t_aging();
    t_link();
    end_sim();
  end
endmodule
